// ### core/rxe_core.sv
`timescale 1ns/10ps
module rxe_core (
  input  wire logic                 i_clock,        // 100 MHz clock
  input  wire logic                 i_rst_n,        // Async reset
  input  wire logic                 i_hw_mode,      // Pin strapped mode
  input  wire logic                 i_error_select_pin, // Strap level
  input  wire logic                 i_port_slave,   // Input port slave
  input  wire logic                 i_out_master,   // Frame clock master
  input  wire logic                 i_direct_fmt,   // Raw direct format
  input  wire logic                 i_pll_locked,   // PLL lock
  input  wire logic                 i_pll_tick,     // PLL clock enable
  input  wire logic                 i_xtal_tick,    // Crystal enable
  input  wire logic                 i_idle_tick,    // Idle osc enable
  input  wire logic                 i_preamble_xz,  // X or Z start
  input  wire logic                 i_z_valid,      // Valid Z seen
  input  wire logic                 i_sub_strobe,   // Subframe boundary
  input  rxe_pkg::rxe_sub_err_s     i_sub_err,      // Subframe errors
  input  wire logic [23:0]          i_sample,       // Decoded sample
  input  wire logic                 i_ext_frame_clk,// Slave frame clock
  input  wire logic                 i_sync_code,    // Burst sync seen
  input  wire logic [15:0]          i_pc,           // Burst Pc
  input  wire logic [15:0]          i_pd,           // Burst Pd
  input  wire logic                 i_cs_bit1,      // Chan status bit 1
  input  wire logic                 i_deemph_auto,  // Auto de-emphasis
  input  rxe_pkg::rxe_fmt_s         i_fmt,          // Format flags
  input  wire logic [7:0]           i_reg_addr,     // Register address
  input  wire logic                 i_reg_wr,       // Write strobe
  input  wire logic                 i_reg_rd,       // Read strobe
  input  wire logic [7:0]           i_reg_wdata,    // Write data
  output logic [7:0]                o_reg_rdata,    // Read data
  output logic                      o_recovered_master_clock, // Master clk
  output logic                      o_on_crystal,   // Crystal in use
  output logic [10:0]               o_pll_mult,     // PLL multiplier
  output logic                      o_output_frame_clock, // Frame clock
  output logic [23:0]               o_sample,       // Output sample
  output logic                      o_any_receiver_error, // Level
  output logic                      o_nonvalidity_receiver_error, // Level
  output logic                      o_error_select_pin, // Hardware pin
  output logic                      o_err_pulse,    // Error pulse
  output logic                      o_nonaudio,     // Non-audio
  output logic                      o_deemph_bypass // Skip de-emphasis
);

  // Ratio code to master/frame multiple
  function automatic logic [10:0] ratio_of(input logic [2:0] sel);
    unique case (sel)
      3'h0:    ratio_of = 11'h040;
      3'h1:    ratio_of = 11'h060;
      3'h2:    ratio_of = 11'h080;
      3'h3:    ratio_of = 11'h0C0;
      3'h4:    ratio_of = 11'h100;
      3'h5:    ratio_of = 11'h180;
      3'h6:    ratio_of = 11'h200;
      3'h7:    ratio_of = 11'h400;
    endcase
  endfunction

  // Registers
  logic [7:0]  clk_ctrl_reg;   // Clock control
  logic [7:0]  ratio_reg;      // Ratio control
  logic [7:0]  err_unm_reg;    // Error unmask
  logic [7:0]  int_unm_reg;    // Interrupt unmask
  logic [7:0]  int_mode_reg;   // Interrupt mode
  logic [7:0]  err_log_reg;    // Sticky error log
  logic [7:0]  int_stat_reg;   // Interrupt status
  logic [15:0] pc_reg;         // Burst Pc
  logic [15:0] pd_reg;         // Burst Pd
  logic        strap_reg;      // Caught strap
  logic        strap_done_reg; // Strap captured
  logic [1:0]  zcnt_reg;       // Z preamble count
  logic [12:0] tmo_reg;        // Sync timeout
  logic        comp_reg;       // compressed_stream_detected
  rxe_pkg::rxe_src_e src_reg;  // Active clock source
  logic [23:0] prev_reg;       // Last sample after hold
  logic [23:0] dly_reg [4];    // Latency line
  logic        ext_fc_reg;     // Last slave clock

  // Combinational error view
  logic [7:0]  cur_err;        // Raw conditions
  logic [7:0]  unm_err;        // Unmasked conditions
  logic        unlock;         // Unlock condition
  logic        sw_on;          // Switching enabled
  logic        any_sel;        // Any-error selected
  logic        hold_hit;       // Sample affected
  logic        tick_sel;       // Chosen source tick
  logic        rd_log;         // Error log read
  rxe_pkg::rxe_src_e src_want; // Wanted source
  rxe_pkg::rxe_hold_e hold_m;  // Hold mode
  logic [23:0] fixed;          // Sample after hold
  logic        take;           // Sample strobe

  assign unlock  = !i_pll_locked || (zcnt_reg < rxe_pkg::Z_NEEDED);
  assign cur_err = {1'b0, i_sub_err.subcode_crc_fault, i_sub_err.chan_status_crc_fault, unlock,
                    i_sub_err.val, i_sub_err.confidence_fault, i_sub_err.biphase_fault,
                    i_sub_err.par};
  assign unm_err = cur_err & err_unm_reg;
  assign sw_on   = i_hw_mode || clk_ctrl_reg[rxe_pkg::CC_SWITCH_EN];
  assign any_sel = i_hw_mode && strap_reg;
  assign rd_log  = i_reg_rd && (i_reg_addr == rxe_pkg::ADDR_ERR_LOG);
  assign hold_m  = rxe_pkg::rxe_hold_e'(
                   clk_ctrl_reg[rxe_pkg::CC_HOLD_HI:rxe_pkg::CC_HOLD_LO]);

  // Which errors touch the sample
  always_comb begin
    if (i_hw_mode) begin
      hold_hit = |(cur_err & ~rxe_pkg::ERR_VAL_MASK)
               || (any_sel && i_sub_err.val);
    end else begin
      hold_hit = |(unm_err & rxe_pkg::ERR_SAMPLE_MASK);
    end
  end

  // Apply hold setting
  always_comb begin
    fixed = i_sample;
    if (hold_hit) begin
      if (i_hw_mode) begin
        fixed = prev_reg;
      end else begin
        unique case (hold_m)
          rxe_pkg::HOLD_PREV: fixed = prev_reg;
          rxe_pkg::HOLD_ZERO: fixed = '0;
          default:            fixed = i_sample;
        endcase
      end
    end
  end

  // Register writes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_ctrl_reg <= rxe_pkg::RST_ZERO;
      ratio_reg    <= rxe_pkg::RST_ZERO;
      err_unm_reg  <= rxe_pkg::RST_ZERO;
      int_unm_reg  <= rxe_pkg::RST_ZERO;
      int_mode_reg <= rxe_pkg::RST_ZERO;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        rxe_pkg::ADDR_CLK_CTRL: clk_ctrl_reg <= i_reg_wdata;
        rxe_pkg::ADDR_RATIO:    ratio_reg    <= i_reg_wdata;
        rxe_pkg::ADDR_ERR_UNM:  err_unm_reg  <= i_reg_wdata;
        rxe_pkg::ADDR_INT_UNM:  int_unm_reg  <= i_reg_wdata;
        rxe_pkg::ADDR_INT_MODE: int_mode_reg <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux, registered
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= rxe_pkg::RST_ZERO;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        rxe_pkg::ADDR_CLK_CTRL: o_reg_rdata <= clk_ctrl_reg;
        rxe_pkg::ADDR_RATIO:    o_reg_rdata <= ratio_reg;
        rxe_pkg::ADDR_ERR_UNM:  o_reg_rdata <= err_unm_reg;
        rxe_pkg::ADDR_INT_UNM:  o_reg_rdata <= int_unm_reg;
        rxe_pkg::ADDR_INT_MODE: o_reg_rdata <= int_mode_reg;
        rxe_pkg::ADDR_FMT:      o_reg_rdata <= {3'h0, i_fmt};
        rxe_pkg::ADDR_ERR_LOG:  o_reg_rdata <= err_log_reg;
        rxe_pkg::ADDR_INT_STAT: o_reg_rdata <= int_stat_reg;
        rxe_pkg::ADDR_PRE0:     o_reg_rdata <= pc_reg[15:8];
        rxe_pkg::ADDR_PRE1:     o_reg_rdata <= pc_reg[7:0];
        rxe_pkg::ADDR_PRE2:     o_reg_rdata <= pd_reg[15:8];
        rxe_pkg::ADDR_PRE3:     o_reg_rdata <= pd_reg[7:0];
        default:                o_reg_rdata <= rxe_pkg::RST_ZERO;
      endcase
    end
  end

  // Sticky error log, set beats read clear
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_log_reg <= rxe_pkg::RST_ZERO;
    end else begin
      err_log_reg <= (rd_log ? 8'h00 : err_log_reg)
                   | (i_sub_strobe ? unm_err : 8'h00);
    end
  end

  // Status snapshot of error activity and burst detection
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_stat_reg <= rxe_pkg::RST_ZERO;
    end else begin
      int_stat_reg <= {6'h00, comp_reg, |err_log_reg};
    end
  end

  // Strap caught after reset release
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg      <= i_error_select_pin;
      strap_done_reg <= 1'b1;
    end
  end

  // Z preamble counter for unlock
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zcnt_reg <= 2'h0;
    end else if (!i_pll_locked) begin
      zcnt_reg <= 2'h0;
    end else if (i_z_valid && zcnt_reg < rxe_pkg::Z_NEEDED) begin
      zcnt_reg <= zcnt_reg + 2'h1;
    end
  end

  // Level error outputs per subframe, and error pulse
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_any_receiver_error         <= 1'b0;
      o_nonvalidity_receiver_error <= 1'b0;
      o_error_select_pin           <= 1'b0;
      o_err_pulse                  <= 1'b0;
    end else begin
      o_err_pulse <= i_sub_strobe && |unm_err;
      if (i_sub_strobe) begin
        o_any_receiver_error <= |unm_err;
        o_nonvalidity_receiver_error <=
          |(unm_err & ~rxe_pkg::ERR_VAL_MASK);
        o_error_select_pin <= strap_reg ? |cur_err
                            : |(cur_err & ~rxe_pkg::ERR_VAL_MASK);
      end
    end
  end

  // Clock source choice
  always_comb begin
    if (i_pll_locked) begin
      src_want = rxe_pkg::SRC_PLL;
    end else if (sw_on) begin
      src_want = rxe_pkg::SRC_XTAL;
    end else begin
      src_want = rxe_pkg::SRC_IDLE;
    end
  end

  always_comb begin
    unique case (src_reg)
      rxe_pkg::SRC_XTAL: tick_sel = i_xtal_tick;
      rxe_pkg::SRC_IDLE: tick_sel = i_idle_tick;
      default:           tick_sel = i_pll_tick;
    endcase
  end

  // Swap source only while clock is low
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_reg <= rxe_pkg::SRC_IDLE;
    end else if (!o_recovered_master_clock && !tick_sel) begin
      src_reg <= src_want;
    end
  end

  // Master clock built from chosen ticks
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_recovered_master_clock <= 1'b0;
      o_on_crystal             <= 1'b0;
    end else begin
      if (tick_sel) begin
        o_recovered_master_clock <= !o_recovered_master_clock;
      end
      o_on_crystal <= (src_reg == rxe_pkg::SRC_XTAL);
    end
  end

  // Multiplier handed to the PLL
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pll_mult <= 11'h000;
    end else if (ratio_reg[rxe_pkg::RC_SRC_BCLK] && i_port_slave
                 && !i_hw_mode) begin
      o_pll_mult <= ratio_of(ratio_reg[2:0])
                    / 11'(rxe_pkg::BCLK_DIV);
    end else begin
      o_pll_mult <= ratio_of(ratio_reg[2:0]);
    end
  end

  // Sample taken at preamble or slave edge
  always_comb begin
    if (i_out_master) begin
      take = i_preamble_xz;
    end else begin
      take = i_ext_frame_clk && !ext_fc_reg;
    end
  end

  // Frame clock aligned to preamble start
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_output_frame_clock <= 1'b0;
      ext_fc_reg           <= 1'b0;
    end else begin
      ext_fc_reg <= i_ext_frame_clk;
      if (i_out_master && i_preamble_xz) begin
        o_output_frame_clock <= !o_output_frame_clock;
      end
    end
  end

  // Previous sample after hold and latency line
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_reg <= '0;
      for (int k = 0; k < 4; k++) begin
        dly_reg[k] <= '0;
      end
    end else if (take) begin
      prev_reg   <= fixed;
      dly_reg[0] <= fixed;
      for (int k = 1; k < 4; k++) begin
        dly_reg[k] <= dly_reg[k-1];
      end
    end
  end

  // Output tap by format
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample <= '0;
    end else if (take) begin
      o_sample <= i_direct_fmt ? dly_reg[1] : dly_reg[2];
    end
  end

  // Burst detection and timeout
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      comp_reg <= 1'b0;
      tmo_reg  <= 13'h0000;
      pc_reg   <= 16'h0000;
      pd_reg   <= 16'h0000;
    end else if (i_sync_code) begin
      comp_reg <= 1'b1;
      tmo_reg  <= 13'h0000;
      pc_reg   <= i_pc;
      pd_reg   <= i_pd;
    end else if (comp_reg && i_preamble_xz) begin
      if (tmo_reg == 13'(rxe_pkg::SYNC_TMO - 1)) begin
        comp_reg <= 1'b0;
      end
      tmo_reg <= tmo_reg + 13'h0001;
    end
  end

  // Non-audio flag and de-emphasis bypass
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nonaudio      <= 1'b0;
      o_deemph_bypass <= 1'b0;
    end else begin
      o_nonaudio      <= comp_reg || i_cs_bit1;
      o_deemph_bypass <= i_deemph_auto && (comp_reg || i_cs_bit1);
    end
  end

  // Checks
  sequence read_log_s;
    rd_log && !i_sub_strobe;
  endsequence

  sticky_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    read_log_s |=> err_log_reg == 8'h00) else $error("log not cleared");
  sticky_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sub_strobe && |unm_err |=> (err_log_reg & $past(unm_err)) == $past(unm_err))
    else $error("error not logged");
  unlock_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_pll_locked |=> unlock) else $error("unlock missing");
  level_out_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sub_strobe |=> o_any_receiver_error == |$past(unm_err))
    else $error("any error level wrong");
  nv_lone_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sub_strobe && unm_err == rxe_pkg::ERR_VAL_MASK
    |=> !o_nonvalidity_receiver_error) else $error("nv on validity");
  glitch_free_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $changed(src_reg) |-> !o_recovered_master_clock) else $error("switch while high");
  pulse_err_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_err_pulse |=> !o_err_pulse || $past(i_sub_strobe)) else $error("pulse stuck");
  nonaudio_or_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ##1 o_nonaudio == ($past(comp_reg) || $past(i_cs_bit1))) else $error("nonaudio wrong");
  mute_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    take && hold_hit && !i_hw_mode && hold_m == rxe_pkg::HOLD_ZERO
    |=> prev_reg == 24'h000000) else $error("mute failed");
  sync_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sync_code |=> comp_reg) else $error("burst flag missing");

endmodule // rxe_core

// ### pkg/rxe_pkg.sv
package rxe_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h02; // Clock control
  localparam logic [7:0] ADDR_RATIO    = 8'h09; // Ratio control
  localparam logic [7:0] ADDR_ERR_UNM  = 8'h0E; // Error unmask
  localparam logic [7:0] ADDR_INT_UNM  = 8'h0F; // Interrupt unmask
  localparam logic [7:0] ADDR_INT_MODE = 8'h10; // Interrupt edge mode
  localparam logic [7:0] ADDR_FMT      = 8'h12; // Format detect
  localparam logic [7:0] ADDR_ERR_LOG  = 8'h13; // Error log
  localparam logic [7:0] ADDR_INT_STAT = 8'h14; // Interrupt status
  localparam logic [7:0] ADDR_PRE0     = 8'h2D; // Pc high byte
  localparam logic [7:0] ADDR_PRE1     = 8'h2E; // Pc low byte
  localparam logic [7:0] ADDR_PRE2     = 8'h2F; // Pd high byte
  localparam logic [7:0] ADDR_PRE3     = 8'h30; // Pd low byte
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00; // All registers
  // Clock control fields
  localparam int CC_SWITCH_EN = 7;   // Crystal fallback enable
  localparam int CC_HOLD_HI   = 3;   // Hold mode high bit
  localparam int CC_HOLD_LO   = 2;   // Hold mode low bit
  // Ratio control fields
  localparam int RC_SRC_BCLK = 3;    // Source is bit clock
  // Error bit positions
  localparam int EB_SUBCODE_CRC_FAULT = 6;
  localparam int EB_CHAN_STATUS_CRC_FAULT = 5;
  localparam int EB_UNLK = 4;
  localparam int EB_VAL  = 3;
  localparam int EB_CONFIDENCE_FAULT = 2;
  localparam int EB_BIP  = 1;
  localparam int EB_PAR  = 0;
  localparam logic [7:0] ERR_SAMPLE_MASK = 8'h1F; // Not CRC bits
  localparam logic [7:0] ERR_VAL_MASK    = 8'h08; // Validity bit
  // Timing and counts
  localparam logic [1:0] Z_NEEDED       = 2'h2;   // Valid Z preambles
  localparam int         BCLK_DIV       = 64;     // Bit clock divider
  localparam int         IDLE_FS_HZ     = 54000;  // VCO idle frame rate
  localparam int         IDLE_BCLK_HZ   = 3456000; // Idle bit clock
  localparam int         IDLE_TOL_PCT   = 5;      // Idle tolerance
  localparam logic [2:0] LAT_DIRECT     = 3'h3;   // Frames, direct
  localparam logic [2:0] LAT_OTHER      = 3'h4;   // Frames, other
  localparam int         SYNC_TMO       = 4096;   // Frames w/o sync
  localparam int         SAMPLE_W       = 24;
  // Hold modes
  typedef enum logic [1:0] {HOLD_PREV, HOLD_ZERO, HOLD_PASS, HOLD_RSV} rxe_hold_e;
  // Clock source states
  typedef enum logic [1:0] {SRC_PLL, SRC_XTAL, SRC_IDLE} rxe_src_e;
  // Per subframe decoder status
  typedef struct packed {
    logic subcode_crc_fault;   // subcode_crc_fault
    logic chan_status_crc_fault;   // chan_status_crc_fault
    logic val;    // Validity bit set
    logic confidence_fault;   // confidence_fault
    logic biphase_fault;    // biphase_fault
    logic par;    // parity_fault
  } rxe_sub_err_s;
  // Format detect flags
  typedef struct packed {
    logic silence;
    logic vendor_b;
    logic vendor_a;
    logic iec_burst;
    logic pcm;
  } rxe_fmt_s;
endpackage

// ### verification/rxe_core_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the receiver status and clock fallback block
module rxe_core_tb;
  logic                  i_clock = 1'b0; // 100 MHz clock
  logic                  i_rst_n = 1'b0; // Reset, active low
  logic                  i_hw_mode, i_error_select_pin, i_port_slave, i_out_master, i_direct_fmt, i_pll_locked;
  logic                  i_pll_tick, i_xtal_tick, i_idle_tick, i_preamble_xz, i_z_valid, i_sub_strobe;
  logic                  i_ext_frame_clk, i_sync_code, i_cs_bit1, i_deemph_auto, i_reg_wr, i_reg_rd, lock_req;
  rxe_pkg::rxe_sub_err_s i_sub_err;      // Subframe error flags
  rxe_pkg::rxe_fmt_s     i_fmt;          // Format flags
  logic [23:0]           i_sample, o_sample;
  logic [15:0]           i_pc, i_pd;
  logic [7:0]            i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [10:0]           o_pll_mult;
  logic                  o_recovered_master_clock, o_on_crystal, o_output_frame_clock, o_any_receiver_error;
  logic                  o_nonvalidity_receiver_error, o_error_select_pin, o_err_pulse, o_nonaudio, o_deemph_bypass;
  int                    mismatches = 0; // Failed comparisons
  int                    compares = 0;   // All comparisons
  integer                seed = 53060;   // Fixed random seed
  // Clock generation
  always #5 i_clock = ~i_clock;
  rxe_core rxe_core_inst (.i_clock, .i_rst_n, .i_hw_mode, .i_error_select_pin, .i_port_slave, .i_out_master,
    .i_direct_fmt, .i_pll_locked, .i_pll_tick, .i_xtal_tick, .i_idle_tick, .i_preamble_xz, .i_z_valid,
    .i_sub_strobe, .i_sub_err, .i_sample, .i_ext_frame_clk, .i_sync_code, .i_pc, .i_pd, .i_cs_bit1,
    .i_deemph_auto, .i_fmt, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
    .o_recovered_master_clock, .o_on_crystal, .o_pll_mult, .o_output_frame_clock, .o_sample,
    .o_any_receiver_error, .o_nonvalidity_receiver_error, .o_error_select_pin, .o_err_pulse, .o_nonaudio,
    .o_deemph_bypass);
  rxe_src_model rxe_src_model_inst (.i_clock, .i_rst_n, .i_lock(lock_req), .o_pll_tick(i_pll_tick),
    .o_xtal_tick(i_xtal_tick), .o_idle_tick(i_idle_tick), .o_locked(i_pll_locked));
  // Counts a comparison and reports a mismatch
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // Register write, taken at the second edge
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clock);
    i_reg_wr    <= 1'b0;
  endtask
  // Register read, data settled just after the taking edge
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clock);
    i_reg_rd   <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  // One subframe with preamble and valid Z; outputs looked at after the taking edge
  task automatic frame(input rxe_pkg::rxe_sub_err_s e, input logic [23:0] s);
    @(posedge i_clock);
    {i_sub_strobe, i_preamble_xz, i_z_valid} <= 3'h7;
    i_sub_err <= e;
    i_sample  <= s;
    @(posedge i_clock);
    {i_sub_strobe, i_preamble_xz, i_z_valid} <= 3'h0;
    #1;
  endtask
  // Unmasked error vector of one subframe while locked
  function automatic logic [7:0] ev(input rxe_pkg::rxe_sub_err_s e, input logic [7:0] m);
    return {1'b0, e.subcode_crc_fault, e.chan_status_crc_fault, 1'b0, e.val, e.confidence_fault, e.biphase_fault, e.par} & m;
  endfunction
  // Verdict and end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [7:0]  m, acc, r, x;
    logic [23:0] sv [8];
    logic [31:0] pcd;
    int          lat;
    {i_hw_mode, i_error_select_pin, i_port_slave, i_out_master, i_direct_fmt, i_preamble_xz} = 6'h0;
    {i_z_valid, i_sub_strobe, i_ext_frame_clk, i_sync_code, i_cs_bit1, i_deemph_auto} = 6'h0;
    {i_reg_wr, i_reg_rd, lock_req, i_reg_addr, i_reg_wdata, i_pc, i_pd, i_sample} = '0;
    i_sub_err = '0;
    i_fmt = 5'($random(seed));
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clock);
    rreg(rxe_pkg::ADDR_ERR_UNM, r);
    chk(r === 8'h00, "unmask reset value");
    rreg(8'h55, r);
    chk(r === 8'h00, "unmapped read");
    // Unlock until locked with two valid Z preambles, then sticky log
    wreg(rxe_pkg::ADDR_ERR_UNM, 8'h10);
    frame('0, 24'h0);
    chk(o_any_receiver_error === 1'b1, "unlock not flagged");
    lock_req <= 1'b1;
    repeat (3) frame('0, 24'h0);
    chk(o_any_receiver_error === 1'b0, "unlock stays after lock");
    rreg(rxe_pkg::ADDR_ERR_LOG, r);
    chk(r === 8'h10, "sticky unlock lost");
    rreg(rxe_pkg::ADDR_ERR_LOG, r);
    chk(r === 8'h00, "log not cleared by read");
    $display("test unlock done");
    // Random errors under random unmask
    acc = 8'h00;
    for (int i = 0; i < 24; i++) begin
      m = 8'($random(seed)) & 8'h7F;
      wreg(rxe_pkg::ADDR_ERR_UNM, m);
      frame(6'($random(seed)), 24'($random(seed)));
      x = ev(i_sub_err, m);
      acc = acc | x;
      chk(o_any_receiver_error === (|x), "any error level");
      chk(o_nonvalidity_receiver_error === (|(x & ~rxe_pkg::ERR_VAL_MASK)), "nonvalidity level");
      chk(o_err_pulse === (|x), "error pulse");
      chk(o_error_select_pin === (|ev(i_sub_err, 8'h77)), "strap error pin");
      if (i % 6 == 5) begin
        rreg(rxe_pkg::ADDR_ERR_LOG, r);
        chk(r === acc, "error log contents");
        chk(o_any_receiver_error === (|x), "level changed by read");
        acc = 8'h00;
      end
    end
    $display("test errors done");
    // Latency in master mode, direct and other formats
    wreg(rxe_pkg::ADDR_ERR_UNM, 8'h00);
    i_out_master <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      i_direct_fmt <= d[0];
      lat = d ? 3 : 4;
      for (int k = 0; k < 8; k++) begin
        sv[k] = 24'($random(seed));
        frame('0, sv[k]);
        if (k >= lat - 1) chk(o_sample === sv[k - lat + 1], "sample latency");
        chk(o_output_frame_clock === !k[0], "frame clock at preamble");
      end
    end
    // Parity error under the prev, zero and pass hold settings, direct format
    wreg(rxe_pkg::ADDR_ERR_UNM, 8'h01);
    for (int h = 0; h < 3; h++) begin
      wreg(rxe_pkg::ADDR_CLK_CTRL, 8'(4 * h));
      sv[0] = 24'($random(seed));
      frame(6'h01, sv[0]);
      sv[1] = (h == 0) ? sv[7] : (h == 1) ? 24'h000000 : sv[0];
      repeat (2) frame('0, 24'h0);
      chk(o_sample === sv[1], "hold mode sample");
    end
    $display("test latency done");
    // Non-audio from status bit and from burst sync, burst preambles
    i_cs_bit1 <= 1'b1;
    i_deemph_auto <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk(o_nonaudio === 1'b1, "status bit non-audio");
    chk(o_deemph_bypass === 1'b1, "de-emphasis bypass");
    i_cs_bit1 <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk(o_nonaudio === 1'b0, "non-audio without cause");
    pcd = $random(seed);
    i_sync_code <= 1'b1;
    {i_pc, i_pd} <= pcd;
    @(posedge i_clock);
    i_sync_code <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk(o_nonaudio === 1'b1, "compressed flag");
    for (int j = 0; j < 4; j++) begin
      rreg(rxe_pkg::ADDR_PRE0 + 8'(j), r);
      chk(r === pcd[31 - 8 * j -: 8], "burst preamble byte");
    end
    rreg(rxe_pkg::ADDR_FMT, r);
    chk(r === {3'h0, i_fmt}, "format status");
    $display("test nonaudio done");
    // Ratio from bit clock or frame rate
    i_port_slave <= 1'b1;
    wreg(rxe_pkg::ADDR_RATIO, 8'h0B);
    @(posedge i_clock);
    #1;
    chk(o_pll_mult === 11'h003, "bit clock ratio");
    i_port_slave <= 1'b0;
    @(posedge i_clock);
    #1;
    chk(o_pll_mult === 11'h0C0, "frame rate ratio");
    // Clock fallback on lock loss
    wreg(rxe_pkg::ADDR_CLK_CTRL, 8'h80);
    lock_req <= 1'b0;
    repeat (20) @(posedge i_clock);
    chk(o_on_crystal === 1'b1, "crystal fallback");
    #1;
    x = {7'h0, o_recovered_master_clock};
    r = 8'h00;
    repeat (16) begin
      @(posedge i_clock);
      #1;
      if (o_recovered_master_clock !== x[0]) r = r + 8'h01;
      x[0] = o_recovered_master_clock;
    end
    chk(r === 8'h04, "crystal rate on master clock");
    wreg(rxe_pkg::ADDR_CLK_CTRL, 8'h00);
    repeat (20) @(posedge i_clock);
    chk(o_on_crystal === 1'b0, "idle source when disabled");
    i_hw_mode <= 1'b1;
    repeat (40) @(posedge i_clock);
    chk(o_on_crystal === 1'b1, "hardware mode fallback");
    $display("test clock done");
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    #500000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule // rxe_core_tb

// ### verification/rxe_src_model.sv
`timescale 1ns/10ps
// Far side of the receiver: clock enables and lock state of the incoming stream
module rxe_src_model (
  input  wire logic i_clock,     // System clock
  input  wire logic i_rst_n,     // Async reset, active low
  input  wire logic i_lock,      // Lock state asked for by the bench
  output logic      o_pll_tick,  // Recovered rate enable
  output logic      o_xtal_tick, // Crystal rate enable
  output logic      o_idle_tick, // Idle oscillator enable
  output logic      o_locked     // PLL lock level
);
  logic [3:0] cnt_reg; // Free running divider
  // Divider for the three source rates, all taken from one counter
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // Lock follows the request one cycle late, as a real loop never locks at once
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_locked <= 1'b0;
    end else begin
      o_locked <= i_lock;
    end
  end
  assign o_pll_tick  = cnt_reg[0];             // Half rate
  assign o_xtal_tick = (cnt_reg[1:0] == 2'h3); // Quarter rate
  assign o_idle_tick = (cnt_reg == 4'hF);      // Slow idle rate
endmodule // rxe_src_model
